// ===== pkg/l5_prn_code_phase_map.svh
// Constant map for the L5 code-phase table and its code generator.
`ifndef L5_PRN_CODE_PHASE_MAP_SVH
`define L5_PRN_CODE_PHASE_MAP_SVH

`define L5_XB_W          13
`define L5_XB_ALL_ONES   13'h1FFF
`define L5_XB_TAPS       13'h18ED
`define L5_PRN_FIRST     7'h40
`define L5_PRN_LAST      7'h63
`define L5_RSV_FIRST     7'h26
`define L5_RSV_LAST      7'h3F
`define L5_PRN_COUNT     36
`define L5_CHECK_LAST    4'hC
`define L5_CNT_ONE       13'h0001
`define L5_CHK_ZERO      4'h0
`define L5_CHK_ONE       4'h1

`endif

// ===== pkg/l5_prn_pkg.sv
// Types shared by the L5 code-phase table, its generator and the chip buffer.
package l5_prn_pkg;

  typedef enum logic {
    BRANCH_I5 = 1'b0,
    BRANCH_Q5 = 1'b1
  } branch_t;

  typedef struct packed {
    logic [6:0] prn;     // Signal number.
    branch_t    branch;  // I5 or Q5 code.
  } code_sel_t;

  typedef struct packed {
    logic [12:0] adv_i;
    logic [12:0] adv_q;
    logic [12:0] st_i;
    logic [12:0] st_q;
  } phase_entry_t;

  typedef struct packed {
    logic chip;   // XB chip value.
    logic first;  // First chip after a load.
  } chip_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADV  = 2'b01,
    ST_RUN  = 2'b10
  } gen_state_t;

endpackage : l5_prn_pkg

// ===== verilog/chip_skid_buffer.sv
// Two-entry buffer for the chip stream; every output comes from a flip-flop.
`timescale 1ns/100ps
`default_nettype none
module chip_skid_buffer (
  input  wire logic                   i_clk,      // Clock.
  input  wire logic                   i_rst_n,    // Synchronous reset, active low.
  input  wire logic                   i_valid,    // Word offered.
  input  wire l5_prn_pkg::chip_word_t i_data,     // Offered word.
  output logic                        o_ready,    // Room for a word.
  output logic                        o_valid,    // Word available.
  output l5_prn_pkg::chip_word_t      o_data,     // Head word.
  input  wire logic                   i_ready     // Receiver takes the word.
);
  import l5_prn_pkg::*;

  chip_word_t out_ff, nxt_out, skid_ff, nxt_skid;
  logic       out_v_ff, nxt_out_v, skid_v_ff, nxt_skid_v;
  logic       push, pop;

  // A registered ready costs the second slot but keeps the path from
  // the receiver's ready back to the generator free of combinational logic.
  always_comb begin
    push       = i_valid & ~skid_v_ff;
    pop        = out_v_ff & i_ready;
    nxt_out    = out_ff;
    nxt_out_v  = out_v_ff;
    nxt_skid   = skid_ff;
    nxt_skid_v = skid_v_ff;
    if (!out_v_ff || pop) begin
      if (skid_v_ff) begin
        nxt_out    = skid_ff;
        nxt_out_v  = 1'b1;
        nxt_skid_v = 1'b0;
      end else begin
        nxt_out   = i_data;
        nxt_out_v = push;
      end
    end else if (push) begin
      nxt_skid   = i_data;
      nxt_skid_v = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      out_ff    <= '0;
      out_v_ff  <= 1'b0;
      skid_ff   <= '0;
      skid_v_ff <= 1'b0;
    end else begin
      out_ff    <= nxt_out;
      out_v_ff  <= nxt_out_v;
      skid_ff   <= nxt_skid;
      skid_v_ff <= nxt_skid_v;
    end
  end

  assign o_ready = ~skid_v_ff;
  assign o_valid = out_v_ff;
  assign o_data  = out_ff;
endmodule : chip_skid_buffer
`default_nettype wire

// ===== verilog/l5_prn_code_phase_table.sv
// L5 XB code-phase table for signal numbers 64 to 99 with its XB code generator.
// Behaviour
// RULE_01: Start state equals all-ones XB state stepped by the listed advance count.
// RULE_02: Start state is first 13 XB chips; rightmost character goes out first.
// RULE_03: First 13 XB chips are the complement of the I5/Q5 code start.
// RULE_04: Signal numbers 38 to 63 are reserved and never handed out.
// RULE_05: Table holds I5 and Q5 advance and start state for numbers 64-99.
// RULE_06: Number 64 uses I5 7789/1000100010001 and Q5 5246/1001101001111.
// RULE_07: Number 99 uses I5 696/1100101001011 and Q5 4438/1000111101101.
// RULE_08: Extra L5 users draw numbers and codes only from this assignment set.
// RULE_09: Self-check compares advanced XB chips with the listed start state.
`timescale 1ns/100ps
`default_nettype none
`include "l5_prn_code_phase_map.svh"
module l5_prn_code_phase_table (
  input  wire logic                   i_clk,          // 100 MHz chip clock.
  input  wire logic                   i_rst_n,        // Synchronous reset, active low.
  input  wire logic                   i_load,         // Pulse: load the selected code.
  input  wire l5_prn_pkg::code_sel_t  i_sel,          // Signal number and branch.
  output logic                        o_busy,         // Advancing the XB register.
  output logic                        o_sel_reserved, // Last selection was 38..63.
  output logic                        o_sel_invalid,  // Last selection outside 38..99.
  output logic [12:0]                 o_code_init,    // Complemented start state.
  output logic                        o_check_done,   // First 13 chips compared.
  output logic                        o_check_ok,     // Those chips matched the table.
  output logic                        o_chip_valid,   // Chip available.
  output l5_prn_pkg::chip_word_t      o_chip,         // Chip and first-chip marker.
  input  wire logic                   i_chip_ready    // Receiver takes the chip.
);
  import l5_prn_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Code-phase table: advance I5, advance Q5, start I5, start Q5.
  localparam phase_entry_t TABLE [`L5_PRN_COUNT] = '{ // [RULE_05]
    '{13'd7789, 13'd5246, 13'b1000100010001, 13'b1001101001111}, // [RULE_06]
    '{13'd2311, 13'd4259, 13'b0001000101111, 13'b0001100100010},
    '{13'd7432, 13'd5907, 13'b0001100111111, 13'b0000111111000},
    '{13'd5155, 13'd3870, 13'b1010101100001, 13'b0011100100111},
    '{13'd1593, 13'd3262, 13'b0101011111001, 13'b0000001010010},
    '{13'd5841, 13'd7387, 13'b0101101100001, 13'b1100111111001},
    '{13'd5014, 13'd3069, 13'b1000101111011, 13'b0111111110010},
    '{13'd1545, 13'd2999, 13'b0111011001111, 13'b0101011111111},
    '{13'd3016, 13'd7993, 13'b0001011011000, 13'b1100001111011},
    '{13'd4875, 13'd7849, 13'b1110000111000, 13'b1110100110101},
    '{13'd2119, 13'd4157, 13'b0111010010001, 13'b1010010110101},
    '{13'd229,  13'd5031, 13'b0001101111000, 13'b0101111101111},
    '{13'd7634, 13'd5986, 13'b1111001010100, 13'b1010110110010},
    '{13'd1406, 13'd4833, 13'b1011101110100, 13'b1101110110001},
    '{13'd4506, 13'd5739, 13'b0000100110000, 13'b1010000100100},
    '{13'd1819, 13'd7846, 13'b1100010000111, 13'b0100110101010},
    '{13'd7580, 13'd898,  13'b0001101111111, 13'b1000011100011},
    '{13'd5446, 13'd2022, 13'b1100110101101, 13'b1100111011010},
    '{13'd6053, 13'd7446, 13'b1101011001011, 13'b0010110001111},
    '{13'd7958, 13'd6404, 13'b1100001101100, 13'b1101101110110},
    '{13'd5267, 13'd155,  13'b1011110110001, 13'b1101111001001},
    '{13'd2956, 13'd7862, 13'b0111010110101, 13'b1100100000000},
    '{13'd3544, 13'd7795, 13'b1100101101101, 13'b1001101000100},
    '{13'd1277, 13'd6121, 13'b1100111011111, 13'b1111011010001},
    '{13'd2996, 13'd4840, 13'b1011111111011, 13'b0110101110111},
    '{13'd1758, 13'd6585, 13'b1110100100111, 13'b0000100111111},
    '{13'd3360, 13'd429,  13'b1111110010100, 13'b1101101001110},
    '{13'd2718, 13'd6020, 13'b0101001111110, 13'b1100111001011},
    '{13'd3754, 13'd200,  13'b0010100100101, 13'b1010111000011},
    '{13'd7440, 13'd1664, 13'b0001111000011, 13'b1110110010110},
    '{13'd2781, 13'd1499, 13'b1100111000000, 13'b1110100011111},
    '{13'd6756, 13'd7298, 13'b1110010101000, 13'b0001101100011},
    '{13'd7314, 13'd1305, 13'b0111000101001, 13'b0001011010110},
    '{13'd208,  13'd7323, 13'b1111101010101, 13'b0000001000111},
    '{13'd5252, 13'd7544, 13'b1010111001101, 13'b1010011000000},
    '{13'd696,  13'd4438, 13'b1100101001011, 13'b1000111101101}  // [RULE_07]
  };

  // Only the additional set is ever served; the reserved block is refused.
  function automatic logic is_assigned(input logic [6:0] prn);
    return (prn >= `L5_PRN_FIRST) && (prn <= `L5_PRN_LAST); // [RULE_08]
  endfunction : is_assigned

  function automatic logic is_reserved(input logic [6:0] prn);
    return (prn >= `L5_RSV_FIRST) && (prn <= `L5_RSV_LAST); // [RULE_04]
  endfunction : is_reserved

  function automatic logic [12:0] xb_step(input logic [12:0] s);
    return {s[11:0], ^(s & `L5_XB_TAPS)};
  endfunction : xb_step

  ////////////////////////////////////////////////////////////////////////////
  // Selection, advance and chip generation.
  gen_state_t  state_ff, nxt_state;
  logic [12:0] xb_ff, nxt_xb;
  logic [12:0] cnt_ff, nxt_cnt;
  logic [12:0] expect_ff, nxt_expect;
  logic [3:0]  chk_ff, nxt_chk;
  logic        pend_ff, nxt_pend;
  logic        rsv_ff, nxt_rsv, inv_ff, nxt_inv;
  logic        done_ff, nxt_done, ok_ff, nxt_ok, busy_ff, nxt_busy;
  logic [12:0] code_init_ff, nxt_code_init;
  logic        check_ok_ff, nxt_check_ok;
  logic        push, buf_ready, start;
  logic [5:0]  idx;
  phase_entry_t ent;
  chip_word_t  word;

  always_comb begin
    idx        = 6'(i_sel.prn - `L5_PRN_FIRST);
    // Numbers outside the table would alias entries 0..35 (below 36) or index past its end (36..63, 100..127); they never start a code.
    ent        = is_assigned(i_sel.prn) ? TABLE[idx] : '0;
    start      = i_load | pend_ff;
    push       = (state_ff == ST_RUN) & buf_ready;
    word.chip  = xb_ff[12];
    word.first = (chk_ff == `L5_CHK_ZERO) & ~done_ff;
    nxt_state  = state_ff;
    nxt_xb     = xb_ff;
    nxt_cnt    = cnt_ff;
    nxt_expect = expect_ff;
    nxt_chk    = chk_ff;
    nxt_pend   = 1'b0;
    nxt_rsv    = rsv_ff;
    nxt_inv    = inv_ff;
    nxt_done   = done_ff;
    nxt_ok     = ok_ff;
    if (start) begin
      nxt_rsv = is_reserved(i_sel.prn);
      nxt_inv = ~is_reserved(i_sel.prn) & ~is_assigned(i_sel.prn);
      if (is_assigned(i_sel.prn)) begin
        nxt_state  = ST_ADV;
        nxt_xb     = `L5_XB_ALL_ONES; // [RULE_01]
        nxt_cnt    = (i_sel.branch == BRANCH_Q5) ? ent.adv_q : ent.adv_i;
        nxt_expect = (i_sel.branch == BRANCH_Q5) ? ent.st_q : ent.st_i;
        nxt_chk    = `L5_CHK_ZERO;
        nxt_done   = 1'b0;
        nxt_ok     = 1'b0;
      end else begin
        nxt_state = ST_IDLE;
      end
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_IDLE;
        end
        ST_ADV: begin
          nxt_xb  = xb_step(xb_ff); // [RULE_01]
          nxt_cnt = cnt_ff - `L5_CNT_ONE;
          if (cnt_ff == `L5_CNT_ONE) begin
            nxt_state = ST_RUN;
            nxt_ok    = 1'b1;
          end
        end
        ST_RUN: begin
          if (push) begin
            nxt_xb = xb_step(xb_ff);
            if (!done_ff) begin
              // Chip k of the stream is bit k of the listed state.
              if (xb_ff[12] != expect_ff[chk_ff]) begin // [RULE_02] [RULE_09]
                nxt_ok = 1'b0;
              end
              nxt_chk = chk_ff + `L5_CHK_ONE;
              if (chk_ff == `L5_CHECK_LAST) begin
                nxt_done = 1'b1;
              end
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
    nxt_busy      = (nxt_state == ST_ADV);
    nxt_code_init = ~nxt_expect; // [RULE_03]
    nxt_check_ok  = nxt_ok & nxt_done;
  end

  // Pending is set by reset so the selection present at release is loaded.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff  <= ST_IDLE;
      xb_ff     <= `L5_XB_ALL_ONES;
      cnt_ff    <= '0;
      expect_ff <= '0;
      chk_ff    <= '0;
      pend_ff   <= 1'b1;
      rsv_ff    <= 1'b0;
      inv_ff    <= 1'b0;
      done_ff   <= 1'b0;
      ok_ff     <= 1'b0;
      busy_ff   <= 1'b0;
      code_init_ff <= `L5_XB_ALL_ONES;
      check_ok_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      xb_ff     <= nxt_xb;
      cnt_ff    <= nxt_cnt;
      expect_ff <= nxt_expect;
      chk_ff    <= nxt_chk;
      pend_ff   <= nxt_pend;
      rsv_ff    <= nxt_rsv;
      inv_ff    <= nxt_inv;
      done_ff   <= nxt_done;
      ok_ff     <= nxt_ok;
      busy_ff   <= nxt_busy;
      code_init_ff <= nxt_code_init;
      check_ok_ff  <= nxt_check_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and chip buffer.
  chip_skid_buffer u_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (push),
    .i_data  (word),
    .o_ready (buf_ready),
    .o_valid (o_chip_valid),
    .o_data  (o_chip),
    .i_ready (i_chip_ready)
  );

  assign o_busy         = busy_ff;
  assign o_sel_reserved = rsv_ff;
  assign o_sel_invalid  = inv_ff;
  assign o_code_init    = code_init_ff;
  assign o_check_done   = done_ff;
  assign o_check_ok     = check_ok_ff;
endmodule : l5_prn_code_phase_table
`default_nettype wire

// ===== test/l5_prn_code_phase_table_sva.sv
// Port checks for the L5 code-phase table.
`timescale 1ns/100ps
`default_nettype none
module l5_table_chk (
  input wire logic                   i_clk,          // Clock.
  input wire logic                   i_rst_n,        // Reset, active low.
  input wire logic                   i_load,         // Load pulse.
  input wire l5_prn_pkg::code_sel_t  i_sel,          // Selection.
  input wire logic                   o_busy,         // Advancing.
  input wire logic                   o_sel_reserved, // Held-back number.
  input wire logic                   o_sel_invalid,  // Unknown number.
  input wire logic [12:0]            o_code_init,    // Code start.
  input wire logic                   o_check_done,   // Check finished.
  input wire logic                   o_check_ok,     // Check passed.
  input wire logic                   o_chip_valid,   // Chip offered.
  input wire l5_prn_pkg::chip_word_t o_chip,         // Chip.
  input wire logic                   i_chip_ready    // Chip taken.
);
  import l5_prn_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic ld_rsv;
  logic ld_ok;
  assign ld_rsv = i_load && i_sel.prn >= 7'h26 && i_sel.prn <= 7'h3F;
  assign ld_ok  = i_load && i_sel.prn >= 7'h40 && i_sel.prn <= 7'h63;
  property p_rsv;
    ld_rsv |=> o_sel_reserved && !o_sel_invalid && !o_busy;
  endproperty
  a_rsv: assert property (p_rsv) else $error("held-back number not refused");
  property p_bad;
    i_load && !ld_rsv && !ld_ok |=> o_sel_invalid && !o_sel_reserved && !o_busy;
  endproperty
  a_bad: assert property (p_bad) else $error("unknown number not refused");
  property p_ok;
    ld_ok |=> o_busy && !o_sel_reserved && !o_sel_invalid;
  endproperty
  a_ok: assert property (p_ok) else $error("valid number did not start");
  property p_init64;
    i_load && i_sel.prn == 7'h40
      |=> o_code_init == (($past(i_sel.branch) == BRANCH_Q5) ? 13'h0CB0 : 13'h0EEE);
  endproperty
  a_init64: assert property (p_init64) else $error("wrong start for 64");
  property p_init99;
    i_load && i_sel.prn == 7'h63
      |=> o_code_init == (($past(i_sel.branch) == BRANCH_Q5) ? 13'h0E12 : 13'h06B4);
  endproperty
  a_init99: assert property (p_init99) else $error("wrong start for 99");
  property p_first;
    o_chip_valid && o_chip.first && !o_busy |-> o_chip.chip == !o_code_init[0];
  endproperty
  a_first: assert property (p_first) else $error("first chip wrong");
  property p_hold;
    o_chip_valid && !i_chip_ready |=> o_chip_valid && $stable(o_chip);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled chip changed");
  property p_min_adv;
    $rose(o_busy) ##0 (!i_load)[*8] |-> o_busy;
  endproperty
  a_min_adv: assert property (p_min_adv) else $error("advance ended too soon");
  property p_ok_done;
    (o_check_ok |-> o_check_done) and ($fell(o_busy) |-> !o_check_done);
  endproperty
  a_ok_done: assert property (p_ok_done) else $error("check ok without done");
  c_rsv: cover property (ld_rsv);
  c_stall: cover property (o_chip_valid && !i_chip_ready);
  c_pass: cover property ($rose(o_check_ok));
endmodule : l5_table_chk
bind l5_prn_code_phase_table l5_table_chk chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_load(i_load), .i_sel(i_sel), .o_busy(o_busy), .o_sel_reserved(o_sel_reserved),
  .o_sel_invalid(o_sel_invalid), .o_code_init(o_code_init), .o_check_done(o_check_done),
  .o_check_ok(o_check_ok), .o_chip_valid(o_chip_valid), .o_chip(o_chip),
  .i_chip_ready(i_chip_ready));
`default_nettype wire

// ===== test/chip_rx_model.sv
// Receiver model that takes chips, stalls at random and keeps the first 13 of a code.
`timescale 1ns/100ps
`default_nettype none
module chip_rx_model (
  input  wire logic                   i_clk,   // Clock.
  input  wire logic                   i_rst_n, // Reset, active low.
  input  wire logic                   i_valid, // Chip offered.
  input  wire l5_prn_pkg::chip_word_t i_chip,  // Offered chip.
  input  wire logic                   i_stall, // Allow random stalls.
  output logic                        o_ready, // Chip taken at the edge.
  output logic [12:0]                 o_head   // First 13 chips, first in bit 0.
);
  import l5_prn_pkg::*;
  logic       stall_ff = 1'b0;
  logic [3:0] idx_ff = 4'hD;
  assign o_ready = !stall_ff;
  always @(posedge i_clk) begin
    stall_ff <= i_stall && ($urandom_range(1) == 0);
    // The marker restarts the replica so chips of an aborted code are never mixed in.
    if (i_rst_n && i_valid && o_ready) begin
      if (i_chip.first) begin
        o_head[0] <= i_chip.chip;
        idx_ff <= 4'h1;
      end else if (idx_ff < 4'hD) begin
        o_head[idx_ff] <= i_chip.chip;
        idx_ff <= idx_ff + 4'h1;
      end
    end
  end
endmodule : chip_rx_model
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the L5 code-phase table with a stalling receiver.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import l5_prn_pkg::*;
  logic        i_clk, i_rst_n, i_load, stall, busy, rsv, bad, done, ok, cvalid, cready;
  code_sel_t   i_sel;
  logic [12:0] init, head;
  chip_word_t  chip;
  int          fail_count = 0;
  int          checks = 0;
  int          idx = 13;
  int          nfirst = 0;
  logic        exp_q[$];
  // Each entry: number, branch, advance count, listed start state.
  logic [33:0] tbl[6] = '{{7'h40, BRANCH_I5, 13'h1E6D, 13'h1111},
    {7'h40, BRANCH_Q5, 13'h147E, 13'h134F}, {7'h63, BRANCH_Q5, 13'h1156, 13'h11ED},
    {7'h4B, BRANCH_I5, 13'h00E5, 13'h0378}, {7'h54, BRANCH_Q5, 13'h009B, 13'h1BC9},
    {7'h5C, BRANCH_Q5, 13'h00C8, 13'h15C3}};
  l5_prn_code_phase_table dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_load(i_load),
    .i_sel(i_sel), .o_busy(busy), .o_sel_reserved(rsv), .o_sel_invalid(bad),
    .o_code_init(init), .o_check_done(done), .o_check_ok(ok), .o_chip_valid(cvalid),
    .o_chip(chip), .i_chip_ready(cready));
  chip_rx_model rx_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(cvalid), .i_chip(chip),
    .i_stall(stall), .o_ready(cready), .o_head(head));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic limit(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      $display("[FAIL] wait expected end seen timeout");
      complete_run();
    end
  endtask : limit
  // Chips after the thirteenth, or left over from an aborted code, are not compared.
  always @(posedge i_clk) begin
    if (i_rst_n === 1'b1 && cvalid === 1'b1 && cready === 1'b1) begin
      if (chip.first === 1'b1) begin
        idx = 0;
        nfirst++;
      end
      if (idx < 13 && exp_q.size() > 0) begin
        chk("chip", {12'h000, exp_q.pop_front()}, {12'h000, chip.chip});
        idx++;
      end
    end
  end
  task automatic run_load(input logic [6:0] p, input branch_t b, input logic [12:0] adv,
                          input logic [12:0] st, input logic pulse);
    int n;
    n = 0;
    i_sel <= {p, b};
    i_load <= pulse;
    for (int k = 0; k < 13; k++) exp_q.push_back(st[k]);
    @(posedge i_clk);
    i_load <= 1'b0;
    #1;
    chk("code_init", ~st, init);
    while (busy === 1'b1 && n < 9000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    limit(n, 9000);
    chk("advance", adv, n[12:0]);
    n = 0;
    while ((done !== 1'b1 || exp_q.size() > 0) && n < 2000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    limit(n, 2000);
    chk("check_ok", 13'h0001, {12'h000, ok});
    chk("head", st, head);
  endtask : run_load
  task automatic refuse(input logic [6:0] p, input logic held);
    int f;
    f = nfirst;
    i_sel <= {p, branch_t'($urandom_range(1))};
    i_load <= 1'b1;
    @(posedge i_clk);
    i_load <= 1'b0;
    #1;
    chk("reserved", {12'h000, held}, {12'h000, rsv});
    chk("invalid", {12'h000, !held}, {12'h000, bad});
    repeat (30) @(posedge i_clk);
    #1;
    chk("busy", 13'h0000, {12'h000, busy});
    chk("codes started", f[12:0], nfirst[12:0]);
  endtask : refuse
  initial begin
    logic [6:0] p;
    void'($urandom(86));
    i_rst_n = 1'b0;
    i_load = 1'b0;
    stall = 1'b0;
    i_sel = {7'h63, BRANCH_I5};
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    run_load(7'h63, BRANCH_I5, 13'h02B8, 13'h194B, 1'b0);
    for (int r = 0; r < 4; r++) begin
      case (r)
        0: p = 7'h26;
        1: p = 7'h3F;
        2: p = 7'($urandom_range(37));
        default: p = 7'h64 + 7'($urandom_range(27));
      endcase
      @(posedge i_clk);
      refuse(p, r < 2);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clk);
      stall <= i[0];
      run_load(tbl[i][33:27], branch_t'(tbl[i][26]), tbl[i][25:13], tbl[i][12:0], 1'b1);
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
